//--- logic/rap_pkg.sv
// Shared constants of the ring alarm serial port
// How it works
// - Send one 40-bit alarm word each frame.
// - Most significant bit first, bit 39 leads.
// - Channel 1 holds bits 39 down to 16.
// - Channel 2 holds bits 15 down to 8.
// - Channel 3 holds bits 7 down to 0.
// - Path RDI is OR of seven faults, LOS and RX_LOSS_OF_FRAME.
// - Line RDI is LOS or RX_LOSS_OF_FRAME or AIS.
// - APS flag after three identical new frames.
// - K1K2 field is the debounced value.
// - FAR_END_BLOCK_ERROR_COUNT field is B3 counter low nibble.
// - Output data changes on falling clock edge.
// - Frame output marks the bit 39 time.
// - Input data and frame taken on rising edges.
// - No loss-of-clock check on input clock.
// - Received word drives the mate outputs, mate register and the mate word and mate change status bits only.
package rap_pkg;
  // ---------------------------------------------------------------
  // Word layout
  // ---------------------------------------------------------------
  localparam int WORD_W = 40;
  localparam int CH_N = 3;
  localparam int FAR_END_BLOCK_ERROR_COUNT_W = 4;
  localparam int K1K2_W = 16;
  localparam int FAULT_N = 7;
  localparam int P_CH1_PRDI = 39;
  localparam int P_CH1_LRDI = 38;
  localparam int P_CH1_APS = 37;
  localparam int P_K1K2_LSB = 21;
  localparam int P_CH1_FAR_END_BLOCK_ERROR_COUNT_LSB = 17;
  localparam int P_CH2_BASE = 8;
  localparam int P_CH3_BASE = 0;
  // Offsets inside the 8-bit slot of channels 2 and 3
  localparam int P_SLOT_PRDI = 7;
  localparam int P_SLOT_LRDI = 6;
  localparam int P_SLOT_APS = 5;
  localparam int DEB_FRAMES = 3;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CORE_CLK_KHZ = 250000;
  localparam int OUT_CLK_KHZ = 5184;
  localparam int FRAME_US = 125;
  // Longest half period, rounded down
  localparam int OUT_HALF_CYCLES = CORE_CLK_KHZ / (2 * OUT_CLK_KHZ);
  localparam int FRAME_BITS = OUT_CLK_KHZ * FRAME_US / 1000;
  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  localparam logic [4:0] ADDR_CTRL = 5'h00;
  localparam logic [4:0] ADDR_STATUS = 5'h04;
  localparam logic [4:0] ADDR_MASK = 5'h08;
  localparam logic [4:0] ADDR_LOCAL = 5'h0c;
  localparam logic [4:0] ADDR_MATE = 5'h10;
  localparam int CTRL_EN_BIT = 0;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam int ST_W = 3;
  localparam int ST_MATE_WORD = 0;
  localparam int ST_APS = 1;
  localparam int ST_MATE_CHG = 2;
  localparam logic [ST_W-1:0] STATUS_RST = 3'h0;
  localparam logic [ST_W-1:0] MASK_RST = 3'h0;
  localparam int RD_RDI_LSB = 16;
  localparam int RD_LRDI_BIT = 19;
  localparam int RD_APS_BIT = 20;
  // Pin order in the input synchroniser
  localparam int PIN_CLK = 0;
  localparam int PIN_DATA = 1;
  localparam int PIN_FRAME = 2;

  typedef enum logic {
    RAP_RX_HUNT = 1'b0,
    RAP_RX_SHIFT = 1'b1
  } rap_rx_state_e;

  function automatic logic [7:0] rap_slot(
    input logic prdi,
    input logic lrdi,
    input logic aps,
    input logic [FAR_END_BLOCK_ERROR_COUNT_W-1:0] far_end_block_error_count
  );
    rap_slot = {prdi, lrdi, aps, 1'b0, far_end_block_error_count};
  endfunction
endpackage

//--- logic/rap_word_if.sv
// Carrier for a captured mate alarm word
`timescale 1ns/1ps
interface rap_word_if;
  logic [rap_pkg::WORD_W-1:0] word;
  logic valid;
  modport rx (output word, output valid);
  modport core (input word, input valid);
endinterface

//--- logic/rap_k1k2_debounce.sv
// Three-frame debouncer for the received K1K2 bytes
`timescale 1ns/1ps
module rap_k1k2_debounce (
  input wire logic core_clk, // Core clock
  input wire logic arst_n, // Async reset
  input wire logic frame_tick, // One pulse per frame
  input wire logic [rap_pkg::K1K2_W-1:0] k1k2_raw, // Bytes this frame
  output logic [rap_pkg::K1K2_W-1:0] k1k2_stable, // Debounced value
  output logic changed // Pulse on new value
);
  logic [rap_pkg::K1K2_W-1:0] last_q, last_d;
  logic [rap_pkg::K1K2_W-1:0] stable_q, stable_d;
  logic [1:0] cnt_q, cnt_d;
  logic chg_q, chg_d;

  always_comb begin
    last_d = last_q;
    stable_d = stable_q;
    cnt_d = cnt_q;
    chg_d = 1'b0;
    if (frame_tick) begin
      last_d = k1k2_raw;
      if (k1k2_raw != last_q) begin
        cnt_d = 2'h1;
      end else if (cnt_q != 2'(rap_pkg::DEB_FRAMES)) begin
        cnt_d = cnt_q + 2'h1;
      end
      // Accept only after three identical frames
      if (cnt_d == 2'(rap_pkg::DEB_FRAMES) && k1k2_raw != stable_q) begin
        stable_d = k1k2_raw;
        chg_d = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      last_q <= '0;
      stable_q <= '0;
      cnt_q <= '0;
      chg_q <= 1'b0;
    end else begin
      last_q <= last_d;
      stable_q <= stable_d;
      cnt_q <= cnt_d;
      chg_q <= chg_d;
    end
  end

  assign k1k2_stable = stable_q;
  assign changed = chg_q;
endmodule

//--- logic/rap_alarm_rx.sv
// Deserialiser for the mate alarm word
`timescale 1ns/1ps
module rap_alarm_rx (
  input wire logic core_clk, // Core clock
  input wire logic arst_n, // Async reset
  input wire logic bit_en, // Rising edge of mate clock seen
  input wire logic bit_data, // Filtered serial data
  input wire logic bit_frame, // Filtered frame pulse
  rap_word_if.rx out // Captured word
);
  localparam int CNT_W = $clog2(rap_pkg::WORD_W);
  rap_pkg::rap_rx_state_e st_q, st_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [rap_pkg::WORD_W-1:0] sh_q, sh_d;
  logic [rap_pkg::WORD_W-1:0] hold_q, hold_d;
  logic vld_q, vld_d;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    hold_d = hold_q;
    vld_d = 1'b0;
    if (bit_en) begin
      sh_d = {sh_q[rap_pkg::WORD_W-2:0], bit_data};
      if (bit_frame) begin
        st_d = rap_pkg::RAP_RX_SHIFT;
        cnt_d = CNT_W'(rap_pkg::WORD_W - 2);
      end else begin
        unique case (st_q)
          rap_pkg::RAP_RX_HUNT: begin
            st_d = rap_pkg::RAP_RX_HUNT;
          end
          rap_pkg::RAP_RX_SHIFT: begin
            if (cnt_q == '0) begin
              hold_d = sh_d;
              vld_d = 1'b1;
              st_d = rap_pkg::RAP_RX_HUNT;
            end else begin
              cnt_d = cnt_q - 1'b1;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= rap_pkg::RAP_RX_HUNT;
      cnt_q <= '0;
      sh_q <= '0;
      hold_q <= '0;
      vld_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      hold_q <= hold_d;
      vld_q <= vld_d;
    end
  end

  assign out.word = hold_q;
  assign out.valid = vld_q;
endmodule

//--- logic/rap_alarm_port.sv
// Ring alarm serial port: word build, shift out, mate receive
`timescale 1ns/1ps
module rap_alarm_port #(
  parameter int B3_CNT_W = 16, // Width of each B3 error counter
  parameter int HALF_CYCLES = rap_pkg::OUT_HALF_CYCLES, // Half period
  parameter int FRAME_BITS = rap_pkg::FRAME_BITS // Bit slots per frame
) (
  input wire logic core_clk, // Core clock, 250 MHz
  input wire logic arst_n, // Async reset
  input wire logic rx_frame_tick, // One pulse per received frame
  input wire logic [rap_pkg::K1K2_W-1:0] rx_k1k2, // Raw K1K2 this frame
  input wire logic [3*rap_pkg::FAULT_N-1:0] path_fault, // 7 per channel
  input wire logic rx_loss_of_signal, // Receive LOS
  input wire logic rx_loss_of_frame, // Receive RX_LOSS_OF_FRAME
  input wire logic rx_line_ais, // Line AIS detected
  input wire logic [3*B3_CNT_W-1:0] b3_error_count, // B3 counters
  output logic alarm_out_serial_data, // Serial alarm word out
  output logic rx_overhead_serial_clock, // Serial clock out
  output logic rx_overhead_frame, // High during bit 39
  input wire logic alarm_in_clock, // Mate gapped clock
  input wire logic alarm_in_serial_data, // Mate serial data
  input wire logic alarm_in_frame, // Mate frame pulse
  output logic [2:0] mate_path_rdi, // Mate path RDI per channel
  output logic [2:0] mate_line_rdi, // Mate line RDI per channel
  output logic [2:0] mate_aps_changed, // Mate APS flag per channel
  output logic [rap_pkg::K1K2_W-1:0] mate_k1k2, // Mate K1K2
  output logic [3*rap_pkg::FAR_END_BLOCK_ERROR_COUNT_W-1:0] mate_far_end_block_error_count, // Mate FAR_END_BLOCK_ERROR_COUNT counts
  output logic mate_word_valid, // Pulse on fresh mate word
  input wire logic [4:0] reg_addr, // Register byte address
  input wire logic [31:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [31:0] reg_rdata, // Read data, next cycle
  output logic irq // Level interrupt
);
  localparam int DIV_W = $clog2(HALF_CYCLES + 1);
  localparam int IDX_W = $clog2(FRAME_BITS);
  localparam int FW = rap_pkg::FAR_END_BLOCK_ERROR_COUNT_W;

  // ---------------------------------------------------------------
  // Local alarm word
  // ---------------------------------------------------------------
  logic [rap_pkg::K1K2_W-1:0] k1k2_stable;
  logic aps_chg;
  logic [2:0] prdi;
  logic lrdi;
  logic [FW-1:0] far_end_block_error_count [3];
  logic aps_pend_q, aps_pend_d;
  logic [rap_pkg::WORD_W-1:0] local_word;

  rap_k1k2_debounce u_deb (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .frame_tick(rx_frame_tick),
    .k1k2_raw(rx_k1k2),
    .k1k2_stable(k1k2_stable),
    .changed(aps_chg)
  );

  always_comb begin
    lrdi = rx_loss_of_signal | rx_loss_of_frame | rx_line_ais;
    for (int c = 0; c < 3; c++) begin
      // LOS and RX_LOSS_OF_FRAME are among the seven, ORed in for safety
      prdi[c] = (|path_fault[c*rap_pkg::FAULT_N +: rap_pkg::FAULT_N])
        | rx_loss_of_signal | rx_loss_of_frame;
      far_end_block_error_count[c] = b3_error_count[c*B3_CNT_W +: FW];
    end
  end

  // Channel 1 wide slot, then the two narrow slots
  always_comb begin
    local_word = '0;
    local_word[rap_pkg::P_CH1_PRDI] = prdi[0];
    local_word[rap_pkg::P_CH1_LRDI] = lrdi;
    local_word[rap_pkg::P_CH1_APS] = aps_pend_q | aps_chg;
    local_word[rap_pkg::P_K1K2_LSB +: rap_pkg::K1K2_W] = k1k2_stable;
    local_word[rap_pkg::P_CH1_FAR_END_BLOCK_ERROR_COUNT_LSB +: FW] = far_end_block_error_count[0];
    local_word[rap_pkg::P_CH2_BASE +: 8] =
      rap_pkg::rap_slot(prdi[1], lrdi, aps_pend_q | aps_chg, far_end_block_error_count[1]);
    local_word[rap_pkg::P_CH3_BASE +: 8] =
      rap_pkg::rap_slot(prdi[2], lrdi, aps_pend_q | aps_chg, far_end_block_error_count[2]);
  end

  // ---------------------------------------------------------------
  // Serial output
  // ---------------------------------------------------------------
  logic [DIV_W-1:0] div_q, div_d;
  logic sclk_q, sclk_d;
  logic [IDX_W-1:0] idx_q, idx_d;
  logic sdata_q, sdata_d;
  logic sframe_q, sframe_d;
  logic [rap_pkg::WORD_W-1:0] word_q, word_d;
  logic ctrl_en_q, ctrl_en_d;

  always_comb begin
    div_d = div_q + 1'b1;
    sclk_d = sclk_q;
    idx_d = idx_q;
    sdata_d = sdata_q;
    sframe_d = sframe_q;
    word_d = word_q;
    aps_pend_d = aps_pend_q | aps_chg;
    if (div_q == DIV_W'(HALF_CYCLES - 1)) begin
      div_d = '0;
      sclk_d = ~sclk_q;
      if (sclk_q) begin
        if (idx_q == IDX_W'(FRAME_BITS - 1)) begin
          idx_d = '0;
        end else begin
          idx_d = idx_q + 1'b1;
        end
        if (idx_d == '0) begin
          word_d = local_word;
          // Snapshot already carries this cycle's change
          aps_pend_d = 1'b0;
        end
        if (int'(idx_d) < rap_pkg::WORD_W) begin
          sdata_d = ctrl_en_q
            & word_d[rap_pkg::WORD_W - 1 - int'(idx_d)];
        end else begin
          sdata_d = 1'b0;
        end
        sframe_d = ctrl_en_q & (idx_d == '0);
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_q <= '0;
      sclk_q <= 1'b0;
      idx_q <= IDX_W'(FRAME_BITS - 1);
      sdata_q <= 1'b0;
      sframe_q <= 1'b0;
      word_q <= '0;
      aps_pend_q <= 1'b0;
    end else begin
      div_q <= div_d;
      sclk_q <= sclk_d;
      idx_q <= idx_d;
      sdata_q <= sdata_d;
      sframe_q <= sframe_d;
      word_q <= word_d;
      aps_pend_q <= aps_pend_d;
    end
  end

  // ---------------------------------------------------------------
  // Mate input synchroniser and edge finder
  // ---------------------------------------------------------------
  // The mate clock is gapped, so a silent clock is normal and raises
  // no alarm: there is no watchdog on it.
  logic [2:0] s1_q, s2_q, s3_q;
  logic [2:0] filt_q, filt_d;
  logic bit_en;

  always_comb begin
    filt_d = filt_q;
    for (int p = 0; p < 3; p++) begin
      if (s2_q[p] == s3_q[p]) begin
        filt_d[p] = s3_q[p];
      end
    end
    // 80 ns mate period leaves many core cycles per half bit
    bit_en = ~filt_q[rap_pkg::PIN_CLK] & filt_d[rap_pkg::PIN_CLK];
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      filt_q <= '0;
    end else begin
      s1_q <= {alarm_in_frame, alarm_in_serial_data, alarm_in_clock};
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= filt_d;
    end
  end

  rap_word_if mate_if ();

  rap_alarm_rx u_rx (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .bit_en(bit_en),
    .bit_data(filt_q[rap_pkg::PIN_DATA]),
    .bit_frame(filt_q[rap_pkg::PIN_FRAME]),
    .out(mate_if.rx)
  );

  // ---------------------------------------------------------------
  // Mate word hold and decode to the mate outputs
  // ---------------------------------------------------------------
  logic [rap_pkg::WORD_W-1:0] mate_q, mate_d;
  logic mvld_q, mvld_d;
  logic mate_chg;

  always_comb begin
    mate_d = mate_q;
    mvld_d = 1'b0;
    mate_chg = 1'b0;
    if (mate_if.valid) begin
      mate_d = mate_if.word;
      mvld_d = 1'b1;
      mate_chg = mate_if.word != mate_q;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mate_q <= '0;
      mvld_q <= 1'b0;
    end else begin
      mate_q <= mate_d;
      mvld_q <= mvld_d;
    end
  end

  assign mate_path_rdi = {mate_q[rap_pkg::P_CH3_BASE + rap_pkg::P_SLOT_PRDI],
    mate_q[rap_pkg::P_CH2_BASE + rap_pkg::P_SLOT_PRDI],
    mate_q[rap_pkg::P_CH1_PRDI]};
  assign mate_line_rdi = {mate_q[rap_pkg::P_CH3_BASE + rap_pkg::P_SLOT_LRDI],
    mate_q[rap_pkg::P_CH2_BASE + rap_pkg::P_SLOT_LRDI],
    mate_q[rap_pkg::P_CH1_LRDI]};
  assign mate_aps_changed = {
    mate_q[rap_pkg::P_CH3_BASE + rap_pkg::P_SLOT_APS],
    mate_q[rap_pkg::P_CH2_BASE + rap_pkg::P_SLOT_APS],
    mate_q[rap_pkg::P_CH1_APS]};
  assign mate_k1k2 = mate_q[rap_pkg::P_K1K2_LSB +: rap_pkg::K1K2_W];
  assign mate_far_end_block_error_count = {mate_q[rap_pkg::P_CH3_BASE +: FW],
    mate_q[rap_pkg::P_CH2_BASE +: FW],
    mate_q[rap_pkg::P_CH1_FAR_END_BLOCK_ERROR_COUNT_LSB +: FW]};
  assign mate_word_valid = mvld_q;

  // ---------------------------------------------------------------
  // Register port and interrupt
  // ---------------------------------------------------------------
  logic [rap_pkg::ST_W-1:0] status_q, status_d;
  logic [rap_pkg::ST_W-1:0] mask_q, mask_d;
  logic [rap_pkg::ST_W-1:0] events;
  logic [31:0] rdata_q, rdata_d;
  logic irq_q, irq_d;

  always_comb begin
    events = '0;
    events[rap_pkg::ST_MATE_WORD] = mvld_d;
    events[rap_pkg::ST_APS] = aps_chg;
    events[rap_pkg::ST_MATE_CHG] = mate_chg;
    ctrl_en_d = ctrl_en_q;
    status_d = status_q;
    mask_d = mask_q;
    rdata_d = '0;
    if (reg_wr) begin
      unique case (reg_addr)
        rap_pkg::ADDR_CTRL: ctrl_en_d = reg_wdata[rap_pkg::CTRL_EN_BIT];
        rap_pkg::ADDR_STATUS: status_d = status_q
          & ~reg_wdata[rap_pkg::ST_W-1:0];
        rap_pkg::ADDR_MASK: mask_d = reg_wdata[rap_pkg::ST_W-1:0];
        default: ;
      endcase
    end
    // New events beat a clear in the same cycle
    status_d = status_d | events;
    if (reg_rd) begin
      unique case (reg_addr)
        rap_pkg::ADDR_CTRL: rdata_d[rap_pkg::CTRL_EN_BIT] = ctrl_en_q;
        rap_pkg::ADDR_STATUS: rdata_d[rap_pkg::ST_W-1:0] = status_q;
        rap_pkg::ADDR_MASK: rdata_d[rap_pkg::ST_W-1:0] = mask_q;
        rap_pkg::ADDR_LOCAL: begin
          rdata_d[rap_pkg::K1K2_W-1:0] = k1k2_stable;
          rdata_d[rap_pkg::RD_RDI_LSB +: 3] = prdi;
          rdata_d[rap_pkg::RD_LRDI_BIT] = lrdi;
          rdata_d[rap_pkg::RD_APS_BIT] = aps_pend_q;
        end
        rap_pkg::ADDR_MATE: begin
          rdata_d[rap_pkg::K1K2_W-1:0] = mate_k1k2;
          rdata_d[rap_pkg::RD_RDI_LSB +: 3] = mate_path_rdi;
          rdata_d[rap_pkg::RD_LRDI_BIT] = mate_line_rdi[0];
          rdata_d[rap_pkg::RD_APS_BIT] = mate_aps_changed[0];
        end
        default: rdata_d = '0;
      endcase
    end
    irq_d = |(status_q & mask_q);
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_en_q <= rap_pkg::CTRL_EN_RST;
      status_q <= rap_pkg::STATUS_RST;
      mask_q <= rap_pkg::MASK_RST;
      rdata_q <= '0;
      irq_q <= 1'b0;
    end else begin
      ctrl_en_q <= ctrl_en_d;
      status_q <= status_d;
      mask_q <= mask_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
    end
  end

  assign alarm_out_serial_data = sdata_q;
  assign rx_overhead_serial_clock = sclk_q;
  assign rx_overhead_frame = sframe_q;
  assign reg_rdata = rdata_q;
  assign irq = irq_q;
endmodule

//--- tb/rap_alarm_port_chk.sv
// Pin-level assertions for the ring alarm serial port
`timescale 1ns/1ps
module rap_alarm_port_chk #(
  parameter int HALF_CYCLES = 24, // Half period
  parameter int FRAME_BITS = 648 // Slots per frame
) (
  input wire logic core_clk, // Clock
  input wire logic arst_n, // Reset
  input wire logic alarm_out_serial_data, // Data out
  input wire logic rx_overhead_serial_clock, // Clock out
  input wire logic rx_overhead_frame, // Frame out
  input wire logic mate_word_valid, // Mate pulse
  input wire logic reg_rd, // Read strobe
  input wire logic [31:0] reg_rdata // Read data
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  logic sc_q;
  logic seen_q;
  logic go_q;
  int hc_q;
  int fc_q;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sc_q <= 1'b0;
      seen_q <= 1'b0;
      go_q <= 1'b0;
      hc_q <= 0;
      fc_q <= 0;
    end else begin
      sc_q <= rx_overhead_serial_clock;
      seen_q <= seen_q || (sc_q != rx_overhead_serial_clock);
      hc_q <= (sc_q != rx_overhead_serial_clock) ? 0 : hc_q + 1;
      // Slot count restarts at the falling edge that opens bit 39
      if (sc_q && !rx_overhead_serial_clock) begin
        fc_q <= rx_overhead_frame ? 1 : fc_q + 1;
        go_q <= go_q || rx_overhead_frame;
      end
    end
  end
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  chk_clk_half: assert property (
    $changed(rx_overhead_serial_clock) && seen_q |-> hc_q == HALF_CYCLES-1)
    else $error("serial clock half period wrong");
  chk_data_on_fall: assert property (
    $changed(alarm_out_serial_data) |-> $fell(rx_overhead_serial_clock))
    else $error("data changed off the falling edge");
  chk_frame_on_fall: assert property (
    $rose(rx_overhead_frame) |-> $fell(rx_overhead_serial_clock))
    else $error("frame rose off the falling edge");
  chk_frame_one_bit: assert property (
    $fell(rx_overhead_serial_clock) && $past(rx_overhead_frame)
    |-> !rx_overhead_frame)
    else $error("frame longer than one bit");
  chk_frame_period: assert property (
    $rose(rx_overhead_frame) && go_q |-> fc_q == FRAME_BITS)
    else $error("frame period wrong");
  chk_tail_low: assert property (
    go_q && fc_q > 40 && !rx_overhead_frame |-> !alarm_out_serial_data)
    else $error("data high after bit 0");
  chk_unused_low: assert property (
    $fell(rx_overhead_serial_clock) && go_q && fc_q inside {23, 27, 35}
    |-> !alarm_out_serial_data)
    else $error("unused bit not low");
  chk_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data outside answer cycle");
  chk_valid_pulse: assert property (
    mate_word_valid |=> !mate_word_valid)
    else $error("mate valid longer than one cycle");
endmodule
bind rap_alarm_port rap_alarm_port_chk #(
  .HALF_CYCLES(HALF_CYCLES), .FRAME_BITS(FRAME_BITS)
) i_rap_alarm_port_chk (
  .core_clk(core_clk), .arst_n(arst_n),
  .alarm_out_serial_data(alarm_out_serial_data),
  .rx_overhead_serial_clock(rx_overhead_serial_clock),
  .rx_overhead_frame(rx_overhead_frame),
  .mate_word_valid(mate_word_valid), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata)
);

//--- tb/rap_mate_model.sv
// Behavioural mate terminator driving the alarm input pins
`timescale 1ns/1ps
module rap_mate_model (
  output logic alarm_in_clock, // Gapped clock
  output logic alarm_in_serial_data, // Data
  output logic alarm_in_frame // Frame pulse
);
  initial begin
    alarm_in_clock = 1'b0;
    alarm_in_serial_data = 1'b0;
    alarm_in_frame = 1'b0;
  end
  // Clock stands low between words; released data shows the inverse
  task automatic send_word(input logic [39:0] w, input logic fr,
    input int n);
    int i;
    #13;
    for (i = 39; i > 39 - n; i--) begin
      alarm_in_serial_data = w[i];
      alarm_in_frame = fr && (i == 39);
      #40 alarm_in_clock = 1'b1;
      #40 alarm_in_clock = 1'b0;
    end
    alarm_in_serial_data = !alarm_in_serial_data;
    alarm_in_frame = 1'b0;
  endtask
endmodule

//--- tb/test_rap_alarm_port.sv
// Self-checking bench for the ring alarm serial port
`timescale 1ns/1ps
module test_rap_alarm_port;
  logic core_clk, arst_n, rx_frame_tick, irq, mate_word_valid;
  logic [15:0] rx_k1k2, mate_k1k2, k;
  logic [20:0] path_fault;
  logic rx_loss_of_signal, rx_loss_of_frame, rx_line_ais;
  logic [47:0] b3_error_count;
  logic alarm_out_serial_data, rx_overhead_serial_clock;
  logic rx_overhead_frame, alarm_in_clock, alarm_in_serial_data;
  logic alarm_in_frame, reg_wr, reg_rd, sc_d, rd_d;
  logic [2:0] mate_path_rdi, mate_line_rdi, mate_aps_changed;
  logic [11:0] mate_far_end_block_error_count;
  logic [4:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [39:0] ow, w;
  logic [39:0] out_q[$];
  logic [39:0] mate_q[$];
  logic [39:0] rd_q[$];
  int n_mismatch, comparisons, seed, i;
  int nb = 40;

  rap_alarm_port #(.HALF_CYCLES(2), .FRAME_BITS(48)) i_rap_alarm_port (
    .core_clk(core_clk), .arst_n(arst_n), .rx_frame_tick(rx_frame_tick),
    .rx_k1k2(rx_k1k2), .path_fault(path_fault),
    .rx_loss_of_signal(rx_loss_of_signal),
    .rx_loss_of_frame(rx_loss_of_frame), .rx_line_ais(rx_line_ais),
    .b3_error_count(b3_error_count),
    .alarm_out_serial_data(alarm_out_serial_data),
    .rx_overhead_serial_clock(rx_overhead_serial_clock),
    .rx_overhead_frame(rx_overhead_frame),
    .alarm_in_clock(alarm_in_clock),
    .alarm_in_serial_data(alarm_in_serial_data),
    .alarm_in_frame(alarm_in_frame), .mate_path_rdi(mate_path_rdi),
    .mate_line_rdi(mate_line_rdi), .mate_aps_changed(mate_aps_changed),
    .mate_k1k2(mate_k1k2), .mate_far_end_block_error_count(mate_far_end_block_error_count),
    .mate_word_valid(mate_word_valid), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq)
  );
  rap_mate_model i_rap_mate_model (
    .alarm_in_clock(alarm_in_clock),
    .alarm_in_serial_data(alarm_in_serial_data),
    .alarm_in_frame(alarm_in_frame)
  );
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    rd_q.push_back(40'(exp));
    @(posedge core_clk);
    reg_rd <= 1'b0;
  endtask
  task automatic tick(input logic [15:0] v);
    @(posedge core_clk);
    rx_k1k2 <= v;
    rx_frame_tick <= 1'b1;
    @(posedge core_clk);
    rx_frame_tick <= 1'b0;
  endtask
  function automatic logic [39:0] enc(input logic aps);
    logic [2:0] p;
    logic l;
    l = rx_loss_of_signal | rx_loss_of_frame | rx_line_ais;
    for (int c = 0; c < 3; c++)
      p[c] = |path_fault[7*c+:7] | rx_loss_of_signal | rx_loss_of_frame;
    enc = {p[0], l, aps, k, b3_error_count[3:0], 1'b0, p[1], l, aps,
      1'b0, b3_error_count[19:16], p[2], l, aps, 1'b0,
      b3_error_count[35:32]};
  endfunction
  // ---------------------------------------------------------------
  // Stimulus
  // ---------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = !core_clk;
  end
  initial begin
    #100000;
    n_mismatch++;
    end_sim();
  end
  initial begin
    seed = 32'h03be_5baa;
    {arst_n, rx_frame_tick, reg_wr, reg_rd, rx_line_ais} = 5'h00;
    {rx_loss_of_signal, rx_loss_of_frame} = 2'h0;
    {rx_k1k2, path_fault, b3_error_count} = 85'h0;
    {reg_addr, reg_wdata} = 37'h0;
    repeat (12) @(posedge core_clk);
    arst_n <= 1'b1;
    rd(rap_pkg::ADDR_CTRL, 32'h0000_0001);
    rd(rap_pkg::ADDR_STATUS, 32'h0000_0000);
    wr(5'h14, 32'hffff_ffff);
    rd(5'h14, 32'h0000_0000);
    rd(rap_pkg::ADDR_MASK, 32'h0000_0000);
    $display("test registers done");
    wr(rap_pkg::ADDR_MASK, 32'h0000_0002);
    k = 16'($random(seed));
    @(posedge rx_overhead_frame);
    tick(k);
    tick(k);
    rd(rap_pkg::ADDR_LOCAL, 32'h0000_0000);
    tick(k);
    @(posedge rx_overhead_frame);
    out_q.push_back(enc(1'b1));
    rd(rap_pkg::ADDR_STATUS, 32'h0000_0002);
    check(40'(irq), 40'h1);
    wr(rap_pkg::ADDR_STATUS, 32'h0000_0002);
    rd(rap_pkg::ADDR_STATUS, 32'h0000_0000);
    check(40'(irq), 40'h0);
    $display("test debounce done");
    for (i = 0; i < 7; i++) begin
      @(posedge core_clk);
      path_fault <= 21'h1 << (3 * i);
      {rx_loss_of_signal, rx_loss_of_frame, rx_line_ais} <= 3'h4 >> i;
      b3_error_count <= {16'($random(seed)), 32'($random(seed))};
      repeat (2) @(posedge rx_overhead_frame);
      out_q.push_back(enc(1'b0));
    end
    @(posedge rx_overhead_frame);
    $display("test serial out done");
    for (i = 0; i < 3; i++) begin
      w = {32'($random(seed)), 8'($random(seed))};
      mate_q.push_back({3'h0, w[7], w[15], w[39], w[6], w[14], w[38],
        w[5], w[13], w[37], w[36:21], w[3:0], w[11:8], w[20:17]});
      if (i == 1) i_rap_mate_model.send_word(~w, 1'b0, 40);
      if (i == 2) i_rap_mate_model.send_word(~w, 1'b1, 20);
      i_rap_mate_model.send_word(w, 1'b1, 40);
      repeat (20) @(posedge core_clk);
      rd(rap_pkg::ADDR_MATE, {11'h0, w[37], w[38], w[7], w[15], w[39],
        w[36:21]});
    end
    wr(rap_pkg::ADDR_STATUS, 32'h0000_0007);
    repeat (500) @(posedge core_clk);
    rd(rap_pkg::ADDR_STATUS, 32'h0000_0000);
    repeat (4) @(posedge core_clk);
    $display("test mate receive done");
    end_sim();
  end
  // ---------------------------------------------------------------
  // Result monitor
  // ---------------------------------------------------------------
  always @(posedge core_clk) begin
    sc_d <= rx_overhead_serial_clock;
    rd_d <= reg_rd;
    if (rd_d)
      check(40'(reg_rdata), rd_q.pop_front());
    if (mate_word_valid && mate_q.size() == 0)
      check(40'h1, 40'h0);
    else if (mate_word_valid)
      check({3'h0, mate_path_rdi, mate_line_rdi, mate_aps_changed,
        mate_k1k2, mate_far_end_block_error_count}, mate_q.pop_front());
    if (rx_overhead_serial_clock && !sc_d) begin
      if (rx_overhead_frame)
        nb = 0;
      if (nb < 40) begin
        ow = {ow[38:0], alarm_out_serial_data};
        nb++;
        if (nb == 40 && out_q.size() > 0)
          check(ow, out_q.pop_front());
      end
    end
  end
endmodule
